/* src/ext_edge_detect.v */
`timescale 1ns/1ns
`default_nettype none

module ext_edge_detect
(
  input  wire core_clk,
  input  wire nrst,
  input  wire extPin,
  input  wire pinBonded,
  input  wire risingSel,
  output wire edgePulse
);

  reg  prevLevel_r;
  wire pinLevel;

  // Unbonded pin reads as one
  assign pinLevel = pinBonded ? extPin : 1'b1;

  always @(posedge core_clk)
  begin
    if (!nrst)
      prevLevel_r <= 1'b1;
    else
      prevLevel_r <= pinLevel;
  end

  assign edgePulse = risingSel ? (pinLevel & ~prevLevel_r) : (~pinLevel & prevLevel_r);

endmodule

`default_nettype wire

/* src/timer16_counter_prescaler.v */
// How it works
// - Timer clock: CPU/2, /4, /8 or external
// - Free-running sixteen-bit up-counter, holds on code 11 with no pin edge
// - Main and alternate views, same value
// - Alternate low read keeps overflow flag
// - Low-byte write forces counter to FFFCh
// - Reset value FFFCh, the only reload
// - Period 131072/262144/524288 CPU cycles internally
// - Unbonded timer pin reads as one
// - Each instance owns counter, prescaler, registers
// - Instances start lockstep at common reset; low-byte write restarts one only
// - Overflow flag with maskable interrupt request
// - FFFFh to 0000h rollover sets flag
// - Flag clears: status read, then main low access
// - High read buffers low until low read
// - Code 11 selects external, edge bit chooses
`timescale 1ns/1ns
`default_nettype none
`include "timer16_defs.vh"

module timer16_counter_prescaler
#(
  parameter ADDR_W = 4
)
(
  input  wire              core_clk,
  input  wire              nrst,
  input  wire [ADDR_W-1:0] regAddr,
  input  wire [7:0]        regWdata,
  input  wire              regWrite,
  input  wire              regRead,
  output reg  [7:0]        regRdata,
  input  wire              ext_clock_pin,
  input  wire              extPinBonded,
  output reg               overflowIrq,
  output reg  [15:0]       counterValue
);

  reg  [15:0] count_r;
  reg  [15:0] countNxt;
  reg  [2:0]  presc_r;
  reg  [7:0]  ctrlOne_r;
  reg  [7:0]  ctrlTwo_r;
  reg         overflow_flag_r;
  reg         overflowNxt;
  reg  [1:0]  clrState_r;
  reg  [1:0]  clrStateNxt;
  reg  [7:0]  lowBuf_r;
  reg  [1:0]  bufState_r;
  reg  [1:0]  bufStateNxt;
  reg  [7:0]  rdataNxt;
  wire [1:0]  clock_select_field;
  wire        overflow_irq_enable;
  wire        ext_edge_select;
  wire        extEdge;
  reg         tick;
  wire        wrLow;
  wire        rdMainLow;
  wire        rdAnyLow;
  wire        rdAnyHigh;
  wire        wrMainLow;
  wire        rdStatus;
  wire        wrCtrlOne;
  wire        wrCtrlTwo;
  wire        lowHeld;
  wire [2:0]  divTap;

  // One-hot states of the flag clear sequence and the read pair
  localparam [1:0] CLR_IDLE  = 2'b01;
  localparam [1:0] CLR_ARMED = 2'b10;
  localparam [1:0] BUF_LIVE  = 2'b01;
  localparam [1:0] BUF_HELD  = 2'b10;

  assign clock_select_field  = ctrlTwo_r[`CR2_CLK_HI:`CR2_CLK_LO];
  assign overflow_irq_enable = ctrlOne_r[`CR1_OVIE_BIT];
  assign ext_edge_select     = ctrlTwo_r[`CR2_EDGE_BIT];

  // Address match helper used by several decodes
  function isAddr;
    input [ADDR_W-1:0] a;
    input [3:0]        target;
    begin
      isAddr = (a == target[ADDR_W-1:0]);
    end
  endfunction

  // Low byte of either view
  function isLowAddr;
    input [ADDR_W-1:0] a;
    begin
      isLowAddr = isAddr(a, `ADDR_CNT_LOW) | isAddr(a, `ADDR_ALT_LOW);
    end
  endfunction

  // High byte of either view
  function isHighAddr;
    input [ADDR_W-1:0] a;
    begin
      isHighAddr = isAddr(a, `ADDR_CNT_HIGH) | isAddr(a, `ADDR_ALT_HIGH);
    end
  endfunction

  assign wrLow     = regWrite & isLowAddr(regAddr);
  assign wrMainLow = regWrite & isAddr(regAddr, `ADDR_CNT_LOW);
  assign rdMainLow = regRead & isAddr(regAddr, `ADDR_CNT_LOW);
  assign rdAnyLow  = regRead & isLowAddr(regAddr);
  assign rdAnyHigh = regRead & isHighAddr(regAddr);
  assign rdStatus  = regRead & isAddr(regAddr, `ADDR_STATUS);
  assign wrCtrlOne = regWrite & isAddr(regAddr, `ADDR_CTRL_ONE);
  assign wrCtrlTwo = regWrite & isAddr(regAddr, `ADDR_CTRL_TWO);
  assign lowHeld   = (bufState_r == BUF_HELD);

  ext_edge_detect u_edge
  (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .extPin    (ext_clock_pin),
    .pinBonded (extPinBonded),
    .risingSel (ext_edge_select),
    .edgePulse (extEdge)
  );

  // Divider taps: tap i fires once every 2^(i+1) cycles
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_tap
      assign divTap[gi] = &presc_r[gi:0];
    end
  endgenerate

  // Tick select; prescaler is private to this instance
  always @*
  begin
    case (clock_select_field)
      `CLK_DIV2: tick = divTap[0];
      `CLK_DIV4: tick = divTap[1];
      `CLK_DIV8: tick = divTap[2];
      `CLK_EXT:  tick = extEdge;
      default:   tick = 1'b0;
    endcase
  end

  // Counter next value; wraps freely so a period is 65536 ticks
  always @*
  begin
    countNxt = count_r;
    if (wrLow)
      countNxt = `CNT_PRESET;
    else if (tick)
      countNxt = count_r + 16'h0001;
  end

  // Clear sequence; alternate low access never fires it
  always @*
  begin
    overflowNxt = overflow_flag_r;
    clrStateNxt = clrState_r;
    case (clrState_r)
      CLR_IDLE:
      begin
        if (rdStatus && overflow_flag_r)
          clrStateNxt = CLR_ARMED;
      end
      CLR_ARMED:
      begin
        if (rdMainLow || wrMainLow)
        begin
          overflowNxt = 1'b0;
          clrStateNxt = CLR_IDLE;
        end
      end
      default:
        clrStateNxt = CLR_IDLE;
    endcase
    // A rollover in the clearing cycle wins
    if (!wrLow && tick && count_r == `CNT_ROLL_FROM)
      overflowNxt = 1'b1;
  end

  // Read pair: high read holds the low byte until a low read
  always @*
  begin
    bufStateNxt = bufState_r;
    case (bufState_r)
      BUF_LIVE:
      begin
        if (rdAnyHigh)
          bufStateNxt = BUF_HELD;
      end
      BUF_HELD:
      begin
        if (rdAnyLow)
          bufStateNxt = BUF_LIVE;
      end
      default:
        bufStateNxt = BUF_LIVE;
    endcase
  end

  // Read mux; high read freezes low byte for the pair
  always @*
  begin
    rdataNxt = 8'h00;
    case (regAddr)
      `ADDR_CNT_HIGH: rdataNxt = count_r[15:8];
      `ADDR_ALT_HIGH: rdataNxt = count_r[15:8];
      `ADDR_CNT_LOW:  rdataNxt = lowHeld ? lowBuf_r : count_r[7:0];
      `ADDR_ALT_LOW:  rdataNxt = lowHeld ? lowBuf_r : count_r[7:0];
      `ADDR_STATUS:   rdataNxt = {overflow_flag_r, 7'h00};
      `ADDR_CTRL_ONE: rdataNxt = ctrlOne_r;
      `ADDR_CTRL_TWO: rdataNxt = ctrlTwo_r;
      default:        rdataNxt = 8'h00;
    endcase
  end

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      count_r <= `CNT_PRESET;
    end
    else
    begin
      count_r <= countNxt;
    end
  end

  // Prescaler restarts with the preset so the first tick is a full period
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      presc_r <= `PRESC_RESET;
    end
    else
    begin
      presc_r <= wrLow ? `PRESC_RESET : presc_r + 3'h1;
    end
  end

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      ctrlOne_r <= `CR1_RESET;
    end
    else
    begin
      if (wrCtrlOne)
        ctrlOne_r <= regWdata;
    end
  end

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      ctrlTwo_r <= `CR2_RESET;
    end
    else
    begin
      if (wrCtrlTwo)
        ctrlTwo_r <= regWdata;
    end
  end

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      overflow_flag_r <= 1'b0;
    end
    else
    begin
      overflow_flag_r <= overflowNxt;
    end
  end

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      clrState_r <= CLR_IDLE;
    end
    else
    begin
      clrState_r <= clrStateNxt;
    end
  end

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      bufState_r <= BUF_LIVE;
    end
    else
    begin
      bufState_r <= bufStateNxt;
    end
  end

  // Repeated high reads keep the first captured low byte
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      lowBuf_r <= 8'h00;
    end
    else
    begin
      if (rdAnyHigh && bufState_r == BUF_LIVE)
        lowBuf_r <= count_r[7:0];
    end
  end

  // Read data stand one cycle and idle at zero
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      regRdata <= 8'h00;
    end
    else
    begin
      regRdata <= regRead ? rdataNxt : 8'h00;
    end
  end

  // CPU-side masking is outside; request stays while flag and enable hold
  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      overflowIrq <= 1'b0;
    end
    else
    begin
      overflowIrq <= overflowNxt & overflow_irq_enable;
    end
  end

  always @(posedge core_clk)
  begin
    if (!nrst)
    begin
      counterValue <= `CNT_PRESET;
    end
    else
    begin
      counterValue <= countNxt;
    end
  end

endmodule

`default_nettype wire

/* src/timer16_defs.vh */
`ifndef TIMER16_DEFS_VH
`define TIMER16_DEFS_VH

// Register offsets on the plain register port
`define ADDR_CNT_HIGH     4'h0
`define ADDR_CNT_LOW      4'h1
`define ADDR_ALT_HIGH     4'h2
`define ADDR_ALT_LOW      4'h3
`define ADDR_STATUS       4'h4
`define ADDR_CTRL_ONE     4'h5
`define ADDR_CTRL_TWO     4'h6

// Field positions
`define STAT_OVF_BIT      7
`define CR1_OVIE_BIT      5
`define CR2_CLK_LO        2
`define CR2_CLK_HI        3
`define CR2_EDGE_BIT      0

// Clock select codes
`define CLK_DIV2          2'h0
`define CLK_DIV4          2'h1
`define CLK_DIV8          2'h2
`define CLK_EXT           2'h3

// Reset, reload and rollover values
`define CNT_PRESET        16'hfffc
`define CNT_ROLL_FROM     16'hffff
`define CR1_RESET         8'h00
`define CR2_RESET         8'h00
`define PRESC_RESET       3'h0

`endif

/* testbench/ext_clock_model.sv */
`timescale 1ns/1ns
`default_nettype none
module ext_clock_model
(
  input  wire logic core_clk,
  output var  logic pinOut
);
  initial pinOut = 1'b0;
  // Idle low between bursts; any gap of 1 or more keeps the far side's ticks at least two cycles apart
  task automatic burst(input int n, input int gap);
    repeat (n)
    begin
      repeat (gap) @(posedge core_clk);
      pinOut <= 1'b1;
      repeat (gap) @(posedge core_clk);
      pinOut <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic        core_clk, nrst, regWrite, regRead, extPinBonded, extPin, overflowIrq;
  logic [3:0]  regAddr;
  logic [7:0]  regWdata, regRdata, d, h;
  logic [15:0] counterValue;
  int          err_count = 0;
  int          n_checks = 0;
  ext_clock_model ext (.core_clk, .pinOut(extPin));
  timer16_counter_prescaler uut (.core_clk, .nrst, .regAddr, .regWdata, .regWrite, .regRead,
    .regRdata, .ext_clock_pin(extPin), .extPinBonded, .overflowIrq, .counterValue);
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= v;
    @(posedge core_clk);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge core_clk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rng(input logic [15:0] got, input logic [15:0] lo);
    n_checks++;
    if ((got >= lo && got <= lo + 16'h3) !== 1'b1)
    begin
      err_count++;
      $display("CHECK FAILED %0t count delta %h", $time, got);
    end
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    test_done;
  end
  initial
  begin
    {nrst, regWrite, regRead, regAddr, regWdata, extPinBonded} = 16'h0001;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    rd(4'h0);
    cmp(d, 8'hff);
    rd(4'h2);
    cmp(d, 8'hff);
    // Second high read must not refresh the low byte held by the first
    rd(4'h1);
    cmp(d, 8'hfc);
    repeat (20) @(posedge core_clk);
    rd(4'h9);
    cmp(d, 8'h00);
    for (int c = 0; c < 3; c++)
    begin
      wr(4'h6, 8'(c << 2));
      wr(4'h1, 8'h00);
      repeat (64) @(posedge core_clk);
      rd(4'h2);
      h = d;
      rd(4'h3);
      rng({h, d} - 16'hfffc, 16'(64 >> (c + 1)));
    end
    wr(4'h6, 8'h00);
    rd(4'h4);
    wr(4'h1, 8'h00);
    wr(4'h5, 8'h20);
    cmp({7'h0, overflowIrq}, 8'h00);
    repeat (20) @(posedge core_clk);
    cmp({7'h0, overflowIrq}, 8'h01);
    wr(4'h5, 8'h00);
    repeat (2) @(posedge core_clk);
    cmp({7'h0, overflowIrq}, 8'h00);
    wr(4'h5, 8'h20);
    rd(4'h4);
    cmp(d & 8'h80, 8'h80);
    rd(4'h3);
    repeat (3) @(posedge core_clk);
    cmp({7'h0, overflowIrq}, 8'h01);
    rd(4'h1);
    repeat (3) @(posedge core_clk);
    cmp({7'h0, overflowIrq}, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      extPinBonded <= (i != 2);
      wr(4'h6, 8'h0c | 8'(i == 0));
      wr(4'h1, 8'h00);
      ext.burst(4, 4 + i);
      repeat (8) @(posedge core_clk);
      cmp(counterValue[15:8], (i == 2) ? 8'hff : 8'h00);
      rd(4'h0);
      cmp(d, (i == 2) ? 8'hff : 8'h00);
      rd(4'h1);
      cmp(d, (i == 2) ? 8'hfc : 8'h00);
    end
    test_done;
  end
endmodule
bind timer16_counter_prescaler timer16_props chk (.core_clk, .nrst, .regAddr, .regWdata,
  .regWrite, .regRead, .regRdata, .ext_clock_pin, .extPinBonded, .overflowIrq, .counterValue);
`default_nettype wire

/* testbench/timer16_props.sv */
`timescale 1ns/1ns
`default_nettype none
module timer16_props
(
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic [3:0]  regAddr,
  input wire logic [7:0]  regWdata,
  input wire logic        regWrite,
  input wire logic        regRead,
  input wire logic [7:0]  regRdata,
  input wire logic        ext_clock_pin,
  input wire logic        extPinBonded,
  input wire logic        overflowIrq,
  input wire logic [15:0] counterValue
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  property p_rst; $rose(nrst) |-> counterValue == 16'hfffc && !overflowIrq; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_jump; counterValue != $past(counterValue) && counterValue != $past(counterValue)
    + 16'h1 |-> counterValue == 16'hfffc && ($past(regWrite) || $past(regWrite, 2)); endproperty
  a_jump: assert property (p_jump) else $error("bad count step");
  // Preset may land right after a tick, so it is let through
  property p_step; $changed(counterValue) && counterValue != 16'hfffc
    |=> $stable(counterValue) || counterValue == 16'hfffc; endproperty
  a_step: assert property (p_step) else $error("ticks too close");
  property p_rdIdle; !$past(regRead) |-> regRdata == 8'h00; endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data without read");
  property p_unmap; $past(regRead && regAddr > 4'h6) |-> regRdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  // Request registers on the same edge as the flag, so look at it where the read samples
  property p_flag; $past(regRead && regAddr == 4'h4) && $past(overflowIrq) |-> regRdata[7];
  endproperty
  a_flag: assert property (p_flag) else $error("status misses flag");
  property p_irqRise; $rose(overflowIrq)
    |-> counterValue < 16'h0003 || $past(regWrite) || $past(regWrite, 2); endproperty
  a_irqRise: assert property (p_irqRise) else $error("request without wrap");
  // Clear by low access drops it one edge on, enable write two edges on
  property p_irqFall; $fell(overflowIrq)
    |-> $past(regRead || regWrite) || $past(regRead || regWrite, 2); endproperty
  a_irqFall: assert property (p_irqFall) else $error("request dropped alone");
  c_wrap: cover property (counterValue == 16'h0000 && $past(counterValue) == 16'hffff);
  c_clr: cover property ($fell(overflowIrq));
  c_ext: cover property (ext_clock_pin && $changed(counterValue));
endmodule
`default_nettype wire
